/* File: hdl/dpis_consts.vh */
`ifndef DPIS_CONSTS_VH
`define DPIS_CONSTS_VH
// Purpose: shared constants of the dram power-up init and mode block
// Assumes: core clock i_mclk at 40 MHz (25 ns)
// Notes: times kept in their own unit, cycle counts derived from them
`define DPIS_CLK_PS 25000
`define DPIS_INIT_WAIT_US 500
`define DPIS_INIT_WAIT_CYC ((`DPIS_INIT_WAIT_US * 1000000) / `DPIS_CLK_PS)
`define DPIS_DLL_LOCK_CYC 512
`define DPIS_CMD_NOP 4'h7
`define DPIS_CMD_MRS 4'h0
`define DPIS_CMD_LONG_IMPEDANCE_CAL_CMD 4'h6
`define DPIS_CMD_DES 4'h8
`define DPIS_MR0_DLL_RST_BIT 8
`define DPIS_MR1_DLL_DIS_BIT 0
`define DPIS_MR_WIDTH 16
`define DPIS_ST_RESET 3'h0
`define DPIS_ST_INIT 3'h1
`define DPIS_ST_WAIT_CKE 3'h2
`define DPIS_ST_ACTIVE 3'h3
`endif

/* File: hdl/dpis_mode_regs.v */
// Purpose: four mode registers written by mode register write commands
// Assumes: write strobe from the same clock domain
// Notes: read data registered; contents undefined until first write
module dpis_mode_regs (
  input wire i_mclk,
  input wire i_rst,
  input wire i_wr,
  input wire [1:0] i_sel,
  input wire [15:0] i_data,
  input wire i_dll_rst_done,
  input wire [1:0] i_rd_sel,
  output reg [15:0] o_rd_data
);
`include "dpis_consts.vh"
  reg [15:0] mem [0:3];
  always @(posedge i_mclk) begin
    if (i_wr) begin
      mem[i_sel] <= i_data;
    end else if (i_dll_rst_done) begin
      mem[2'h0][`DPIS_MR0_DLL_RST_BIT] <= 1'b0;
    end
  end
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= 16'h0000;
    end else begin
      o_rd_data <= mem[i_rd_sel];
    end
  end
endmodule

/* File: hdl/dpis_init_seq.v */
// Purpose: device-side power-up and reset init tracker for a ddr3l dram
// Assumes: command, cke, termination pins arrive from the controller's domain
// Notes: only device obligations are enforced; the rest is observed
`include "dpis_consts.vh"
module dpis_init_seq #(
  parameter INIT_WAIT_CYC = `DPIS_INIT_WAIT_CYC
) (
  input wire i_mclk,
  input wire i_rst,
  input wire i_reset_n,
  input wire i_cke,
  input wire i_cs_n,
  input wire i_ras_n,
  input wire i_cas_n,
  input wire i_we_n,
  input wire [2:0] i_bank,
  input wire [15:0] i_addr,
  input wire i_termination_control_input,
  input wire [1:0] i_mr_rd_sel,
  output reg o_term_enable,
  output reg o_init_done,
  output reg o_dll_locked,
  output reg o_seq_error,
  output reg [2:0] o_state,
  output wire [15:0] o_mr_rd_data
);
  localparam ST_RESET = 3'h0;
  localparam ST_INIT = 3'h1;
  localparam ST_WAIT_CKE = 3'h2;
  localparam ST_MR = 3'h3;
  localparam ST_CAL = 3'h4;
  localparam ST_READY = 3'h5;

  // two-flop synchronisers for all pins; first stage feeds only the second
  reg [25:0] sync1;
  reg [25:0] sync2;
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= 26'h0000000;
      sync2 <= 26'h0000000;
    end else begin
      sync1 <= {i_termination_control_input, i_addr, i_bank, i_we_n, i_cas_n,
                i_ras_n, i_cs_n, i_cke, i_reset_n};
      sync2 <= sync1;
    end
  end
  wire s_reset_n = sync2[0];
  wire s_cke = sync2[1];
  // command code is {cs_n, ras_n, cas_n, we_n}, the order of the header codes
  wire [3:0] s_cmd = {sync2[2], sync2[3], sync2[4], sync2[5]};
  wire [2:0] s_bank = sync2[8:6];
  wire [15:0] s_addr = sync2[24:9];
  wire [15:0] s_addr_full = s_addr;
  wire s_cmd_idle = s_cmd[3] | (s_cmd == `DPIS_CMD_NOP);
  wire s_mrs = ~s_cmd[3] & (s_cmd == `DPIS_CMD_MRS) & s_cke;
  wire s_long_impedance_cal_cmd = ~s_cmd[3] & (s_cmd == `DPIS_CMD_LONG_IMPEDANCE_CAL_CMD) & s_addr_full[10] & s_cke;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] cnt;
  reg [1:0] mr_step;
  reg dll_pend;
  reg [9:0] dll_cnt;
  reg mr_wr;
  reg [1:0] mr_sel;
  reg [15:0] mr_data;
  reg dll_rst_done;

  // expected bank code per step: register 2, 3, 1, 0
  function [1:0] exp_sel;
    input [1:0] step;
    begin
      case (step)
        2'h0: exp_sel = 2'h2;
        2'h1: exp_sel = 2'h3;
        2'h2: exp_sel = 2'h1;
        default: exp_sel = 2'h0;
      endcase
    end
  endfunction

  always @* begin
    next_state = state;
    case (state)
      ST_RESET: if (s_reset_n) next_state = ST_INIT;
      ST_INIT: if (cnt == 32'h00000000) next_state = ST_WAIT_CKE;
      ST_WAIT_CKE: if (s_cke) next_state = ST_MR;
      ST_MR: if (s_mrs && mr_step == 2'h3) next_state = ST_CAL;
      ST_CAL: if (s_long_impedance_cal_cmd) next_state = ST_READY;
      ST_READY: next_state = ST_READY;
      default: next_state = ST_RESET;
    endcase
    // warm or cold reset restarts the whole sequence
    if (!s_reset_n) next_state = ST_RESET;
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_RESET;
      cnt <= 32'h00000000;
      mr_step <= 2'h0;
      dll_pend <= 1'b0;
      dll_cnt <= 10'h000;
      mr_wr <= 1'b0;
      mr_sel <= 2'h0;
      mr_data <= 16'h0000;
      dll_rst_done <= 1'b0;
      o_term_enable <= 1'b0;
      o_init_done <= 1'b0;
      o_dll_locked <= 1'b0;
      o_seq_error <= 1'b0;
      o_state <= ST_RESET;
    end else begin
      state <= next_state;
      o_state <= next_state;
      mr_wr <= 1'b0;
      dll_rst_done <= 1'b0;
      if (state == ST_RESET) begin
        cnt <= INIT_WAIT_CYC - 1;
      end else if (state == ST_INIT && cnt != 32'h00000000) begin
        cnt <= cnt - 32'h00000001;
      end
      // termination held off until clock enable registered after reset
      o_term_enable <= (next_state == ST_MR || next_state == ST_CAL ||
                        next_state == ST_READY) && sync2[25];
      if (s_mrs && state >= ST_MR) begin
        // mode writes only touch mode storage, never the array
        mr_wr <= 1'b1;
        mr_sel <= s_bank[1:0];
        mr_data <= s_addr;
        if (state == ST_MR) begin
          if (s_bank[1:0] != exp_sel(mr_step) || s_bank[2]) o_seq_error <= 1'b1;
          mr_step <= mr_step + 2'h1;
        end
        if (s_bank[1:0] == 2'h0 && s_addr[`DPIS_MR0_DLL_RST_BIT]) begin
          dll_pend <= 1'b1;
          dll_cnt <= 10'h000;
          o_dll_locked <= 1'b0;
        end
      end else if (dll_pend) begin
        if (dll_cnt == `DPIS_DLL_LOCK_CYC - 1) begin
          dll_pend <= 1'b0;
          dll_rst_done <= 1'b1;
          o_dll_locked <= 1'b1;
        end else begin
          dll_cnt <= dll_cnt + 10'h001;
        end
      end
      // state reached ready only after calibration; done waits for dll lock
      o_init_done <= (next_state == ST_READY) && !dll_pend &&
                     (o_dll_locked || dll_rst_done);
      if (next_state == ST_RESET) begin
        mr_step <= 2'h0;
        o_init_done <= 1'b0;
        o_dll_locked <= 1'b0;
        dll_pend <= 1'b0;
        o_term_enable <= 1'b0;
        o_seq_error <= 1'b0;
      end
      if (state == ST_CAL && !s_cmd_idle && !s_long_impedance_cal_cmd) o_seq_error <= 1'b1;
    end
  end

  // contents left undefined after reset until written
  dpis_mode_regs u_mode_regs (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_wr(mr_wr),
    .i_sel(mr_sel),
    .i_data(mr_data),
    .i_dll_rst_done(dll_rst_done),
    .i_rd_sel(i_mr_rd_sel),
    .o_rd_data(o_mr_rd_data)
  );
endmodule

/* File: sim/dpis_init_seq_asserts.sv */
// Purpose: port checker for the init tracker
// Assumes: one clock, async reset high
// Notes: pins act two to three cycles late, checks allow that
module dpis_init_seq_asserts #(
  parameter INIT_WAIT_CYC = 20
) (
  input wire i_mclk,
  input wire i_rst,
  input wire i_reset_n,
  input wire i_cke,
  input wire o_term_enable,
  input wire [2:0] o_state
);
  timeunit 1ns;
  timeprecision 100ps;
  integer n_init;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  always @(posedge i_mclk or posedge i_rst)
    if (i_rst || o_state == 3'h0) n_init <= 0;
    else if (o_state == 3'h1) n_init <= n_init + 1;
  a_init_wait_len:
    assert property (o_state == 3'h2 |-> n_init >= INIT_WAIT_CYC - 1) else $error("init short");
  a_cke_ignored:
    assert property (o_state == 3'h1 |=> o_state != 3'h3) else $error("early enable taken");
  a_term_off_early:
    assert property (o_state < 3'h3 |-> !o_term_enable) else $error("termination early");
  a_term_after_cke:
    assert property ($rose(o_term_enable) |-> $past(i_cke, 2) || $past(i_cke, 3))
      else $error("termination without enable");
  a_pin_reset_idle:
    assert property (!i_reset_n [*4] |-> o_state == 3'h0 && !o_term_enable)
      else $error("pin reset ignored");
endmodule
bind dpis_init_seq dpis_init_seq_asserts #(.INIT_WAIT_CYC(INIT_WAIT_CYC)) u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_reset_n(i_reset_n), .i_cke(i_cke),
  .o_term_enable(o_term_enable), .o_state(o_state));

/* File: sim/dpis_ctrl_model.sv */
// Purpose: controller model driving reset, clock enable and commands
// Assumes: o_cmd is {cs_n, ras_n, cas_n, we_n} in the header codes
// Notes: waits are cycle counts given by the caller, apart from the fixed ones in issue and wake
`include "dpis_consts.vh"
module dpis_ctrl_model (
  input wire i_mclk,
  output reg o_reset_n = 1'b0,
  output reg o_cke = 1'b0,
  output reg [3:0] o_cmd = `DPIS_CMD_DES,
  output reg [2:0] o_bank = 3'h0,
  output reg [15:0] o_addr = 16'h0000,
  output reg o_odt = 1'b1
);
  timeunit 1ns;
  timeprecision 100ps;
  // termination input never moves, held static high through init
  // every wait below is a cycle count handed in by the caller, except issue's one-cycle command slot and wake's eight cycles after enable
  task cyc(input integer n);
    repeat (n) @(posedge i_mclk);
  endtask
  // deselected address shows the inverse, never a stale value
  // issued with clock enable high, except the NOP in wake, and no burst open
  task issue(input [3:0] c, input [2:0] b, input [15:0] a, input integer gap);
    begin
      o_cmd <= c;
      o_bank <= b;
      o_addr <= a;
      cyc(1);
      o_cmd <= `DPIS_CMD_DES;
      o_addr <= ~a;
      cyc(gap);
    end
  endtask
  task hold_reset(input integer n);
    begin
      o_cke <= 1'b0;
      o_reset_n <= 1'b0;
      cyc(n);
      o_reset_n <= 1'b1;
    end
  endtask
  // clock runs free, so stable long before enable
  task wake(input integer n);
    begin
      cyc(n);
      issue(`DPIS_CMD_NOP, 3'h0, 16'h0000, 0);
      o_cke <= 1'b1;
      cyc(8);
    end
  endtask
endmodule

/* File: sim/dram_power_up_init_and_mode_setup_test.sv */
// Purpose: bench for the init tracker against a controller model
// Assumes: internal init wait cut to 20 cycles
// Notes: expected mode contents kept by the bench
`include "dpis_consts.vh"
module dram_power_up_init_and_mode_setup_test;
  timeunit 1ns;
  timeprecision 100ps;
  reg i_mclk = 1'b0;
  reg i_rst = 1'b1;
  reg [1:0] sel = 2'h0;
  reg [31:0] seed = 32'h000140B6;
  reg [15:0] mr_exp [0:3];
  reg [15:0] v;
  reg [1:0] b;
  integer errors = 0;
  integer n_checks = 0;
  integer k;
  wire rn, cke, termination_control_input, term, done, lock, serr;
  wire [3:0] cmd;
  wire [2:0] bank, st;
  wire [15:0] addr, rd;
  dpis_ctrl_model u_ctrl (.i_mclk(i_mclk), .o_reset_n(rn), .o_cke(cke), .o_cmd(cmd),
    .o_bank(bank), .o_addr(addr), .o_odt(termination_control_input));
  dpis_init_seq #(.INIT_WAIT_CYC(20)) DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_reset_n(rn),
    .i_cke(cke), .i_cs_n(cmd[3]), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]),
    .i_bank(bank), .i_addr(addr), .i_termination_control_input(termination_control_input), .i_mr_rd_sel(sel),
    .o_term_enable(term), .o_init_done(done), .o_dll_locked(lock), .o_seq_error(serr),
    .o_state(st), .o_mr_rd_data(rd));
  function [31:0] xs(input [31:0] s);
    begin
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
    end
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("mismatch %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // status packed as {state, term, done, lock, error}
  task flags(input [15:0] e);
    begin
      @(negedge i_mclk);
      chk("status", e, {9'h000, st, term, done, lock, serr});
    end
  endtask
  task run_init(input [7:0] ord, input integer gap, input integer rst_len);
    begin
      @(posedge i_mclk);
      u_ctrl.hold_reset(rst_len);
      flags(16'h0000);
      @(posedge i_mclk);
      u_ctrl.o_cke <= 1'b1;
      u_ctrl.cyc(10);
      u_ctrl.o_cke <= 1'b0;
      flags(16'h0010);
      u_ctrl.wake(20);
      flags(16'h0038);
      @(posedge i_mclk);
      for (k = 0; k < 4; k = k + 1) begin
        b = ord[6 - 2 * k +: 2];
        seed = xs(seed);
        v = {1'b0, seed[14:0]};
        if (b == 2'h1) v[0] = 1'b0;
        if (b == 2'h0) v[8] = 1'b1;
        mr_exp[b] = (b == 2'h0) ? (v & 16'hFEFF) : v;
        u_ctrl.issue(`DPIS_CMD_MRS, {1'b0, b}, v, gap);
      end
      u_ctrl.issue(`DPIS_CMD_LONG_IMPEDANCE_CAL_CMD, 3'h0, 16'h0400, 0);
      for (k = 0; k < 1000 && done !== 1'b1; k = k + 1)
        @(negedge i_mclk);
      chk("order error", {15'h0000, ord != 8'hB4}, {15'h0000, serr});
      if (ord == 8'hB4) begin
        flags(16'h005E);
        for (k = 0; k < 4; k = k + 1) begin
          @(posedge i_mclk);
          sel <= k[1:0];
          repeat (3) @(negedge i_mclk);
          chk("mode reg", mr_exp[k], rd);
        end
      end
    end
  endtask
  initial
    forever #12.5 i_mclk = ~i_mclk;
  // three inits of about six hundred cycles each
  initial begin
    #400000;
    errors = errors + 1;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    run_init(8'hB4, 2, 40);
    run_init(8'hB4, 12, 5);
    run_init(8'hE4, 2, 5);
    report_and_stop;
  end
endmodule
